// *** src/serial_rx_map.vh ***
// constants for the serial receiver: sampling points, frame layout, reset values
// What this block does
// - done flag high while buffer holds frames
// - receiver disable flushes the buffer
// - irq follows done flag and enable
// - error flags stored per buffer entry
// - data read pops oldest entry
// - error flags read-only, never interrupt
// - framing error from first stop bit
// - overrun when buffer, staging fifo, hold word and shifter full
// - overrun clears on successful transfer
// - parity error zero when checking off
// - parity computed odd or even, compared
// - parity error needs mismatch and enable
// - disable aborts frame, releases pin
// - sample at 16x or 8x baud
// - falling edge starts detection, sample one
// - start vote on samples 8-10 or 4-6
// - reject noise start, else synchronise
// - 16 or 8 states, centre vote
// - shift bits to stop, then store
`ifndef SERIAL_RX_MAP_VH
`define SERIAL_RX_MAP_VH
`define RX_SAMPLES_NORMAL  5'd16
`define RX_SAMPLES_DOUBLE  5'd8
`define RX_VOTE_FIRST_NORM 5'd8
`define RX_VOTE_FIRST_DBL  5'd4
`define RX_TICK_DIV_RESET  16'h0043
`define RX_FIFO_DEPTH      16
`define RX_FIFO_AW         4
`define RX_BUF_ENTRIES     2
`define RX_ENTRY_W         12
`define RX_FE_POS          9
`define RX_DOR_POS         10
`define RX_UPE_POS         11
`define RX_B8_POS          8
`endif

// *** src/rx_fifo.v ***
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rx_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // clock and reset
   input  wire             mclk_i,
   input  wire             rst_b_i,
   input  wire             flush_i,
   // fill side
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   // drain side
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [AW:0]      level_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;

   assign in_ready_o  = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr];
   assign level_o     = count;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge mclk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else if (flush_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** src/rx_tick_gen.v ***
// oversampling tick divider: one-cycle enable at the sample rate
`timescale 1ns/1ps
`default_nettype none
module rx_tick_gen (
   // clock and reset
   input  wire        mclk_i,
   input  wire        rst_b_i,
   // control
   input  wire        enable_i,
   input  wire [15:0] divisor_i,
   // tick
   output reg         tick_o
);
   reg [15:0] count;

   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count  <= 16'h0000;
         tick_o <= 1'b0;
      end else if (!enable_i) begin
         count  <= 16'h0000;
         tick_o <= 1'b0;
      end else if (count >= divisor_i) begin
         count  <= 16'h0000;
         tick_o <= 1'b1;
      end else begin
         count  <= count + 16'h0001;
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** src/serial_rx.v ***
// serial receiver: start detect, data recovery, two-entry buffer and status
`timescale 1ns/1ps
`default_nettype none
`include "serial_rx_map.vh"
module serial_rx (
   // clock and reset
   input  wire        mclk_i,
   input  wire        rst_b_i,
   // serial pin
   input  wire        rxd_i,
   output wire        rxd_override_o,
   // control
   input  wire        receiver_enable_bit_i,
   input  wire        rx_done_irq_enable_i,
   input  wire        double_speed_select_i,
   input  wire        parity_enable_bit_i,
   input  wire        parity_type_bit_i,
   input  wire        stop_bits_select_i,
   input  wire [2:0]  char_size_i,
   input  wire [15:0] tick_divisor_i,
   // data register read
   input  wire        data_read_i,
   output reg  [7:0]  serial_data_register_o,
   // status
   output reg         rx_done_flag_o,
   output reg         framing_error_flag_o,
   output reg         overrun_flag_o,
   output reg         parity_error_flag_o,
   output reg         ninth_received_bit_o,
   output wire        rx_done_irq_o,
   // stream side of the staging fifo
   output wire        stage_ready_o
);
   localparam ST_IDLE  = 2'd0;
   localparam ST_START = 2'd1;
   localparam ST_DATA  = 2'd2;
   localparam ST_HOLD  = 2'd3;

   reg        rst_m;
   reg        rst_s;
   reg        rxd_a;
   reg        rxd_b;
   reg        rxd_c;
   reg        rxd_f;
   reg        rxd_prev;
   reg [1:0]  state;
   reg [4:0]  sample;
   reg [3:0]  bit_idx;
   reg [2:0]  votes;
   reg [9:0]  shreg;
   reg        frame_fe;
   reg        frame_pe;
   reg        lost;
   reg [`RX_ENTRY_W-1:0] hold_word;
   reg        hold_valid;
   reg [`RX_ENTRY_W-1:0] buf_mem [0:`RX_BUF_ENTRIES-1];
   reg        buf_rd;
   reg        buf_wr;
   reg [1:0]  buf_cnt;
   reg [8:0]  aligned_data;
   reg        par_calc;
   reg [9:0]  tmp;
   integer    k;

   wire        tick;
   wire [4:0]  spb;
   wire [4:0]  vfirst;
   wire        vote_bit;
   wire [3:0]  nbits;
   wire [3:0]  last_idx;
   wire        s_valid;
   wire [`RX_ENTRY_W-1:0] s_data;
   wire        buf_full;
   wire        buf_push;
   wire        buf_pop;
   wire        flush;
   wire [`RX_ENTRY_W-1:0] head;

   // majority of three samples
   function maj3;
      input [2:0] v;
      begin
         maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
      end
   endfunction

   // sample lies in the three-sample voting window
   function in_window;
      input [4:0] s;
      input [4:0] first;
      begin
         in_window = (s >= first) && (s <= first + 5'd2);
      end
   endfunction

   // sample right after the window, where the vote is final
   function at_decide;
      input [4:0] s;
      input [4:0] first;
      begin
         at_decide = (s == first + 5'd3);
      end
   endfunction

   // reset release
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_m <= 1'b0;
         rst_s <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_s <= rst_m;
      end
   end

   assign flush = ~receiver_enable_bit_i;
   assign rxd_override_o = receiver_enable_bit_i;

   rx_tick_gen u_tick (
      .mclk_i    (mclk_i),
      .rst_b_i   (rst_s),
      .enable_i  (receiver_enable_bit_i),
      .divisor_i (tick_divisor_i),
      .tick_o    (tick)
   );

   assign spb    = double_speed_select_i ? `RX_SAMPLES_DOUBLE :
                   `RX_SAMPLES_NORMAL;
   assign vfirst = double_speed_select_i ? `RX_VOTE_FIRST_DBL :
                   `RX_VOTE_FIRST_NORM;
   assign vote_bit = maj3(votes);
   assign nbits    = 4'd5 + {1'b0, char_size_i} +
                     {3'b000, parity_enable_bit_i};
   assign last_idx = nbits;

   // pin synchroniser, change accepted when second and third agree
   always @(posedge mclk_i or negedge rst_s) begin
      if (!rst_s) begin
         rxd_a <= 1'b1;
         rxd_b <= 1'b1;
         rxd_c <= 1'b1;
         rxd_f <= 1'b1;
      end else begin
         rxd_a <= rxd_i;
         rxd_b <= rxd_a;
         rxd_c <= rxd_b;
         if (rxd_b == rxd_c) begin
            rxd_f <= rxd_c;
         end
      end
   end

   // receive state machine
   always @(posedge mclk_i or negedge rst_s) begin
      if (!rst_s) begin
         state      <= ST_IDLE;
         sample     <= 5'd0;
         bit_idx    <= 4'd0;
         votes      <= 3'b000;
         shreg      <= 10'h000;
         rxd_prev   <= 1'b1;
         frame_fe   <= 1'b0;
         frame_pe   <= 1'b0;
         lost       <= 1'b0;
         hold_word  <= {`RX_ENTRY_W{1'b0}};
         hold_valid <= 1'b0;
      end else if (flush) begin
         state      <= ST_IDLE;
         sample     <= 5'd0;
         bit_idx    <= 4'd0;
         votes      <= 3'b000;
         rxd_prev   <= 1'b1;
         lost       <= 1'b0;
         hold_valid <= 1'b0;
      end else begin
         if (hold_valid && stage_ready_o) begin
            hold_valid <= 1'b0;
         end
         // ahead of the tick logic, so a start bit seen in the
         // same cycle still moves the state on to ST_START
         if (state == ST_HOLD && !hold_valid) begin
            hold_word  <= {frame_pe & parity_enable_bit_i, lost, frame_fe,
                           aligned_data};
            hold_valid <= 1'b1;
            state      <= ST_IDLE;
            // overrun mark travels with this frame only
            lost       <= 1'b0;
         end
         if (tick) begin
            rxd_prev <= rxd_f;
            case (state)
               ST_IDLE, ST_HOLD: begin
                  if (rxd_prev && !rxd_f) begin
                     state  <= ST_START;
                     // next tick is sample two
                     sample <= 5'd2;
                     votes  <= 3'b000;
                     // overrun: shifter frame dropped, buffer kept
                     // the set wins over the clear above
                     if (state == ST_HOLD && hold_valid) begin
                        lost <= 1'b1;
                     end
                  end
               end
               ST_START: begin
                  if (in_window(sample, vfirst)) begin
                     votes <= {votes[1:0], rxd_f};
                  end
                  if (at_decide(sample, vfirst)) begin
                     if (vote_bit) begin
                        state <= ST_IDLE;
                     end else begin
                        state   <= ST_DATA;
                        bit_idx <= 4'd0;
                     end
                  end
                  sample <= sample + 5'd1;
               end
               ST_DATA: begin
                  if (in_window(sample, vfirst)) begin
                     votes <= {votes[1:0], rxd_f};
                  end
                  if (at_decide(sample, vfirst)) begin
                     if (bit_idx == last_idx) begin
                        frame_fe <= ~vote_bit;
                        state    <= ST_HOLD;
                     end else begin
                        shreg   <= {vote_bit, shreg[9:1]};
                        bit_idx <= bit_idx + 4'd1;
                     end
                  end
                  if (sample == spb) begin
                     sample <= 5'd1;
                  end else begin
                     sample <= sample + 5'd1;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // align lsb-first shift register and compute parity
   always @* begin
      tmp = shreg >> (4'd10 - nbits);
      aligned_data = 9'h000;
      par_calc = parity_type_bit_i;
      for (k = 0; k < 9; k = k + 1) begin
         if (k < 5 + char_size_i) begin
            aligned_data[k] = tmp[k];
            par_calc = par_calc ^ tmp[k];
         end
      end
   end

   always @(posedge mclk_i or negedge rst_s) begin
      if (!rst_s) begin
         frame_pe <= 1'b0;
      end else if (state == ST_DATA && tick && at_decide(sample, vfirst) &&
                   bit_idx == last_idx) begin
         frame_pe <= parity_enable_bit_i &
                     (par_calc ^ tmp[5 + char_size_i]);
      end
   end

   rx_fifo #(
      .WIDTH (`RX_ENTRY_W),
      .DEPTH (`RX_FIFO_DEPTH),
      .AW    (`RX_FIFO_AW)
   ) u_stage (
      .mclk_i      (mclk_i),
      .rst_b_i     (rst_s),
      .flush_i     (flush),
      .in_data_i   (hold_word),
      .in_valid_i  (hold_valid),
      .in_ready_o  (stage_ready_o),
      .out_data_o  (s_data),
      .out_valid_o (s_valid),
      .out_ready_i (~buf_full),
      .level_o     ()
   );

   // two-entry receive buffer
   assign buf_full = (buf_cnt == 2'd2);
   assign buf_push = s_valid & ~buf_full;
   assign buf_pop  = data_read_i & (buf_cnt != 2'd0);
   assign head     = buf_mem[buf_rd];

   always @(posedge mclk_i or negedge rst_s) begin
      if (!rst_s) begin
         buf_rd  <= 1'b0;
         buf_wr  <= 1'b0;
         buf_cnt <= 2'd0;
      end else if (flush) begin
         buf_rd  <= 1'b0;
         buf_wr  <= 1'b0;
         buf_cnt <= 2'd0;
      end else begin
         if (buf_push) begin
            buf_mem[buf_wr] <= s_data;
            buf_wr          <= ~buf_wr;
         end
         if (buf_pop) begin
            buf_rd <= ~buf_rd;
         end
         buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   // status views of the oldest entry
   always @(posedge mclk_i or negedge rst_s) begin
      if (!rst_s) begin
         serial_data_register_o <= 8'h00;
         ninth_received_bit_o   <= 1'b0;
         framing_error_flag_o   <= 1'b0;
         overrun_flag_o         <= 1'b0;
         parity_error_flag_o    <= 1'b0;
         rx_done_flag_o         <= 1'b0;
      end else begin
         serial_data_register_o <= head[7:0];
         ninth_received_bit_o   <= head[`RX_B8_POS];
         framing_error_flag_o   <= head[`RX_FE_POS];
         overrun_flag_o         <= head[`RX_DOR_POS];
         parity_error_flag_o    <= head[`RX_UPE_POS] & parity_enable_bit_i;
         // done flag tracks occupancy; from the current count
         // so it rises in the same cycle as the views above
         rx_done_flag_o <= ~flush & (buf_cnt != 2'd0);
      end
   end

   // level irq follows the done flag
   // error flags stay out of the request
   assign rx_done_irq_o = rx_done_flag_o & rx_done_irq_enable_i;
endmodule
`default_nettype wire

// *** test/serial_rx_chk.sv ***
// port assertions for the serial receiver
`timescale 1ns/1ps
`default_nettype none
module serial_rx_chk (
   // clock and reset
   input wire logic       mclk_i,
   input wire logic       rst_b_i,
   // control
   input wire logic       receiver_enable_bit_i,
   input wire logic       rx_done_irq_enable_i,
   input wire logic       parity_enable_bit_i,
   input wire logic       data_read_i,
   // status and data
   input wire logic [7:0] serial_data_register_o,
   input wire logic       rx_done_flag_o,
   input wire logic       framing_error_flag_o,
   input wire logic       overrun_flag_o,
   input wire logic       parity_error_flag_o,
   input wire logic       rx_done_irq_o,
   input wire logic       rxd_override_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // enabled, unread head, nobody popping
   sequence s_head;
      receiver_enable_bit_i && rx_done_flag_o && !data_read_i;
   endsequence
   property p_irq;
      rx_done_irq_o == (rx_done_flag_o && rx_done_irq_enable_i);
   endproperty
   property p_flush;
      !receiver_enable_bit_i [*3] |-> !rx_done_flag_o;
   endproperty
   property p_pin;
      rxd_override_o == receiver_enable_bit_i;
   endproperty
   property p_par_off;
      !parity_enable_bit_i |=> !parity_error_flag_o;
   endproperty
   property p_rise;
      $rose(rx_done_flag_o) |-> $past(receiver_enable_bit_i);
   endproperty
   // flag only drops after a pop or a disable
   property p_fall;
      $fell(rx_done_flag_o) |-> $past(data_read_i) ||
         $past(data_read_i, 2) || !$past(receiver_enable_bit_i) ||
         !$past(receiver_enable_bit_i, 2);
   endproperty
   property p_en_quiet;
      $rose(receiver_enable_bit_i) |=> !rx_done_flag_o [*8];
   endproperty
   property p_hold;
      s_head [*3] |-> $stable(serial_data_register_o) &&
         $stable(framing_error_flag_o) && $stable(overrun_flag_o) &&
         $stable(parity_error_flag_o);
   endproperty
   a_irq: assert property (p_irq) else $error("irq wrong");
   a_flush: assert property (p_flush) else $error("no flush");
   a_pin: assert property (p_pin) else $error("pin owner");
   a_par_off: assert property (p_par_off) else $error("par");
   a_rise: assert property (p_rise) else $error("done rose");
   a_fall: assert property (p_fall) else $error("done fell");
   a_en_quiet: assert property (p_en_quiet) else $error("stale");
   a_hold: assert property (p_hold) else $error("head moved");
endmodule
bind serial_rx serial_rx_chk chk (
   .mclk_i(mclk_i), .rst_b_i(rst_b_i),
   .receiver_enable_bit_i(receiver_enable_bit_i),
   .rx_done_irq_enable_i(rx_done_irq_enable_i),
   .parity_enable_bit_i(parity_enable_bit_i),
   .data_read_i(data_read_i),
   .serial_data_register_o(serial_data_register_o),
   .rx_done_flag_o(rx_done_flag_o),
   .framing_error_flag_o(framing_error_flag_o),
   .overrun_flag_o(overrun_flag_o),
   .parity_error_flag_o(parity_error_flag_o),
   .rx_done_irq_o(rx_done_irq_o), .rxd_override_o(rxd_override_o));
`default_nettype wire

// *** test/serial_tx_model.sv ***
// remote transmitter model driving the serial line
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
   input  wire logic clk_i,
   output var  logic line_o
);
   // idle line rests high
   initial line_o = 1'b1;
   task automatic bit_out(input logic v, input int bt);
      line_o = v;
      repeat (bt) @(negedge clk_i);
   endtask
   // start, lsb first, parity, one stop, one idle bit
   task automatic send(input logic [8:0] d, input int nb, bt,
      input logic pen, podd, bad, stp);
      logic p;
      // parity only over the bits that go on the line
      p = podd ^ bad;
      bit_out(1'b0, bt);
      for (int n = 0; n < nb; n++) begin
         bit_out(d[n], bt);
         p = p ^ d[n];
      end
      if (pen) bit_out(p, bt);
      bit_out(stp, bt);
      bit_out(1'b1, bt);
   endtask
   // short low pulse, noise only
   task automatic glitch(input int k);
      bit_out(1'b0, k);
      line_o = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** test/serial_rx_test.sv ***
// self-checking bench for the serial receiver
`timescale 1ns/1ps
`default_nettype none
module serial_rx_test;
   logic       mclk_i = 1'b0, rst_b_i = 1'b0, rxd_i, en = 1'b0;
   logic       ie = 1'b0, dbl = 1'b0, pen = 1'b0, podd = 1'b0;
   logic       sbs = 1'b0, rd = 1'b0, full_seen = 1'b0;
   logic [2:0] csz = 3'h3;
   logic [7:0] dat;
   logic       fe, overrun_flag, pe, b8, done, irq, ovr, srdy;
   int         err_total = 0, n_compared = 0, bt = 64;
   always #4 mclk_i = ~mclk_i;
   always @(negedge mclk_i) if (srdy === 1'b0) full_seen = 1'b1;
   serial_tx_model tx (.clk_i(mclk_i), .line_o(rxd_i));
   // divisor 3: tick every 4 clocks, 64 clocks a bit
   serial_rx dut (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .rxd_i(rxd_i),
      .rxd_override_o(ovr), .receiver_enable_bit_i(en),
      .rx_done_irq_enable_i(ie), .double_speed_select_i(dbl),
      .parity_enable_bit_i(pen), .parity_type_bit_i(podd),
      .stop_bits_select_i(sbs), .char_size_i(csz),
      .tick_divisor_i(16'h0003), .data_read_i(rd),
      .serial_data_register_o(dat), .rx_done_flag_o(done),
      .framing_error_flag_o(fe), .overrun_flag_o(overrun_flag),
      .parity_error_flag_o(pe), .ninth_received_bit_o(b8),
      .rx_done_irq_o(irq), .stage_ready_o(srdy));
   task automatic chk(input logic [7:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results;
      if (err_total == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wait_done;
      int k;
      for (k = 0; k < 4000 && done !== 1'b1; k++) @(negedge mclk_i);
      if (k == 4000) begin
         err_total++;
         $display("[ERR] %0t no frame", $time);
         results;
      end
   endtask
   task automatic snd(input logic [8:0] d, input logic bad = 0,
      input logic stp = 1);
      tx.send(d, int'(csz) + 5, bt, pen, podd, bad, stp);
   endtask
   task automatic pull;
      rd = 1'b1;
      @(negedge mclk_i);
      rd = 1'b0;
      repeat (2) @(negedge mclk_i);
   endtask
   // error flags are outputs only, the bench never writes them
   // status views read before the pop
   task automatic pop(input logic [7:0] d, input logic f, o, p);
      chk(done, 1'b1);
      chk(dat, d);
      chk(fe, f);
      chk(overrun_flag, o);
      chk(pe, p);
      pull;
   endtask
   task automatic t_basic;
      ie = 1'b1;
      snd(9'h0a5);
      wait_done;
      chk(ovr, 1'b1);
      chk(irq, 1'b1);
      ie = 1'b0;
      @(negedge mclk_i);
      chk(irq, 1'b0);
      ie = 1'b1;
      // handler pops to drop the request
      pop(8'ha5, 0, 0, 0);
      chk(irq, 1'b0);
      pull;
      chk(done, 1'b0);
   endtask
   task automatic t_frame;
      sbs = 1'b1;
      snd(9'h03c, 0, 0);
      snd(9'h0c3);
      wait_done;
      pop(8'h3c, 1, 0, 0);
      pop(8'hc3, 0, 0, 0);
      sbs = 1'b0;
   endtask
   task automatic t_parity;
      pen = 1'b1;
      for (int i = 0; i < 4; i++) begin
         podd = i[0];
         snd(9'h05b, i[0] ^ i[1]);
         wait_done;
         pop(8'h5b, 0, 0, i[0] ^ i[1]);
      end
      pen = 1'b0;
   endtask
   task automatic t_double;
      dbl = 1'b1;
      bt = 32;
      csz = 3'h4;
      snd(9'h1e7);
      wait_done;
      chk(b8, 1'b1);
      pop(8'he7, 0, 0, 0);
      csz = 3'h0;
      snd(9'h1f6);
      wait_done;
      pop(8'h16, 0, 0, 0);
      csz = 3'h3;
   endtask
   task automatic t_noise;
      dbl = 1'b0;
      bt = 64;
      tx.glitch(24);
      repeat (200) @(negedge mclk_i);
      chk(done, 1'b0);
      snd(9'h081);
      wait_done;
      pop(8'h81, 0, 0, 0);
   endtask
   // reader stalls while frames pile up
   task automatic t_overrun;
      int k, nd;
      nd = 0;
      dbl = 1'b1;
      bt = 32;
      for (int i = 0; i < 22; i++) snd(i[8:0]);
      wait_done;
      chk(dat, 8'h00);
      chk(full_seen, 1'b1);
      for (k = 0; k < 30 && done === 1'b1; k++) begin
         if (overrun_flag === 1'b1) nd++;
         pull;
      end
      chk(nd > 0, 1'b1);
      chk(k < 22, 1'b1);
      snd(9'h033);
      wait_done;
      pop(8'h33, 0, 0, 0);
   endtask
   task automatic t_disable;
      snd(9'h011);
      snd(9'h022);
      chk(done, 1'b1);
      fork
         snd(9'h044);
         begin
            repeat (5 * bt) @(negedge mclk_i);
            en = 1'b0;
         end
      join
      chk(done, 1'b0);
      chk(ovr, 1'b0);
      en = 1'b1;
      repeat (4 * bt) @(negedge mclk_i);
      chk(done, 1'b0);
      snd(9'h055);
      wait_done;
      pop(8'h55, 0, 0, 0);
   endtask
   initial begin
      repeat (16) @(negedge mclk_i);
      rst_b_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      en = 1'b1;
      t_basic;
      t_frame;
      t_parity;
      t_double;
      t_noise;
      t_overrun;
      t_disable;
      results;
   end
endmodule
`default_nettype wire
